//--- hw/bmm_pkg.sv
// Purpose: constants for the bus memory module
// Assumes: 250 MHz system clock
// Notes:   bus cycle times expressed in ns and derived cycle counts
package bmm_pkg;
  localparam int          DATA_W        = 16;
  localparam int          ADDR_W        = 16;
  localparam int          RAM_WORDS     = 4096;
  localparam int          RAM_AW        = 12;
  localparam int          ROM_WORDS     = 512;
  localparam int          ROM_AW        = 9;
  localparam int          BANK_W        = 4;
  localparam logic [15:0] ROM_BASE      = 16'hFF00;
  localparam logic [15:0] ROM_TOP       = 16'hFFFF;
  localparam int          CLK_PERIOD_NS = 4;
  localparam int          NORM_CYC_NS   = 1050;
  localparam int          EXT_CYC_NS    = 1750;
  // extra time a read-only access holds the extended-cycle line
  localparam int          EXT_HOLD_NS   = EXT_CYC_NS - NORM_CYC_NS;
  localparam int          EXT_HOLD_CYC  = (EXT_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CNT_W         = 8;
  localparam logic [15:0] ROM_FILL      = 16'h0000;
endpackage : bmm_pkg

//--- hw/bmm_store.sv
// Purpose: 16-bit word store with registered read data
// Assumes: single port, synchronous write
// Notes:   read-only variant ignores writes
`timescale 1ns/100ps
module bmm_store
  import bmm_pkg::*;
#(
  parameter int   AW       = 12,
  parameter bit   WRITABLE = 1'b1
)(
  input  wire logic              clk,
  input  wire logic              we,
  input  wire logic [AW-1:0]     addr,
  input  wire logic [DATA_W-1:0] wdata,
  output logic      [DATA_W-1:0] rdata
);
  logic [DATA_W-1:0] mem [0:(1<<AW)-1];

  initial
  begin
    for (int i = 0; i < (1 << AW); i++)
    begin
      mem[i] = ROM_FILL;
    end
  end

  always_ff @(posedge clk)
  begin
    if (WRITABLE && we)
    begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule : bmm_store

//--- hw/bmm_memory.sv
// Purpose: memory slave on the shared asynchronous system bus
// Assumes: bus lines synchronous to MCLK; bank strap static
// Notes:   read-only store optional through ROM_EN parameter
// Summary of operation
// R01 - 4096 by 16 read/write store
// R02 - optional 512-word read-only store
// R03 - answer memory cycles only in range
// R04 - range base from static bank strap
// R05 - read-only access extends cycle to 1.75us
// R06 - read-only at FF00-FFFF, writes ignored
// R07 - master granted by priority for one cycle
// R08 - master addresses one slave per cycle
// R09 - slave drives data only on reads
// R10 - sample address/data only under strobes
// R11 - accept memory-type transactions only
// R12 - extended-cycle line lengthens slow accesses
// R13 - response line confirms accepted order
// R14 - all transfers over shared bus
// R15 - out of range: no drive, no response
`timescale 1ns/100ps
module bmm_memory
  import bmm_pkg::*;
#(
  parameter bit ROM_EN = 1'b1
)(
  input  wire logic              MCLK,
  input  wire logic              RESET_N,
  input  wire logic [BANK_W-1:0] BANK_SEL,
  input  wire logic              ADDR_STB,
  input  wire logic              DATA_STB,
  input  wire logic [ADDR_W-1:0] ADDR,
  input  wire logic              MEM_SEL,
  input  wire logic              RD_WR_N,
  input  wire logic [DATA_W-1:0] DATA_IN,
  output logic      [DATA_W-1:0] DATA_OUT,
  output logic                   DATA_OE,
  output logic                   EXT_CYCLE,
  output logic                   RESPOND
);
  typedef enum logic [1:0] {ST_IDLE, ST_HOLD, ST_ACT} bmm_state_t;

  function automatic logic in_rom(input logic [ADDR_W-1:0] a);
    in_rom = ROM_EN && (a >= ROM_BASE) && (a <= ROM_TOP);
  endfunction : in_rom

  bmm_state_t        state_q, state_d;
  logic [ADDR_W-1:0] addr_q;
  logic              rd_q;
  logic              rom_q;
  logic [CNT_W-1:0]  cnt_q;
  logic [DATA_W-1:0] ram_rdata;
  logic [DATA_W-1:0] rom_rdata;
  logic              drive_q;
  logic              ext_q;
  logic              resp_q;

  // address phase decode
  wire logic hit_rom  = in_rom(ADDR);                                 // R06
  wire logic hit_ram  = (ADDR[ADDR_W-1 -: BANK_W] == BANK_SEL) && !hit_rom; // R04
  wire logic take     = ADDR_STB && MEM_SEL && (hit_ram || hit_rom) && state_q == ST_IDLE; // R03 R10 R11 R15
  wire logic ram_we   = state_q != ST_IDLE && !rom_q && !rd_q && DATA_STB; // R10
  wire logic ext_done = cnt_q == CNT_W'(0);
  wire logic stb_gone = !ADDR_STB;
  // hold the taken address for the rest of the cycle
  wire logic [RAM_AW-1:0] ram_addr = take ? ADDR[RAM_AW-1:0] : addr_q[RAM_AW-1:0];
  wire logic [ROM_AW-1:0] rom_addr = take ? ADDR[ROM_AW-1:0] : addr_q[ROM_AW-1:0];
  wire logic [DATA_W-1:0] rd_word  = rom_q ? rom_rdata : ram_rdata;
  // answer one cycle after entry, so the read word is already registered
  wire logic              drive_d  = state_q == ST_ACT && rd_q;

  bmm_store #(.AW(RAM_AW), .WRITABLE(1'b1)) u_ram                     // R01
  (
    .clk   (MCLK),
    .we    (ram_we),
    .addr  (ram_addr),
    .wdata (DATA_IN),
    .rdata (ram_rdata)
  );

  bmm_store #(.AW(ROM_AW), .WRITABLE(1'b0)) u_rom                     // R02 R06
  (
    .clk   (MCLK),
    .we    (1'b0),
    .addr  (rom_addr),
    .wdata (DATA_IN),
    .rdata (rom_rdata)
  );

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: if (take) state_d = in_rom(ADDR) ? ST_HOLD : ST_ACT;
      ST_HOLD: if (ext_done) state_d = ST_ACT;                        // R05 R12
      ST_ACT:  if (stb_gone) state_d = ST_IDLE;                      // R07 R08
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      state_q <= ST_IDLE;
      addr_q  <= '0;
      rd_q    <= 1'b0;
      rom_q   <= 1'b0;
      cnt_q   <= '0;
    end
    else
    begin
      state_q <= state_d;
      if (take)
      begin
        addr_q <= ADDR;
        rd_q   <= RD_WR_N;
        rom_q  <= hit_rom;
        cnt_q  <= CNT_W'(EXT_HOLD_CYC - 1);                          // R05
      end
      else if (state_q == ST_HOLD && !ext_done)
      begin
        cnt_q <= cnt_q - CNT_W'(1);
      end
    end
  end

  // bus outputs, all registered
  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      DATA_OUT <= '0;
      drive_q  <= 1'b0;
      ext_q    <= 1'b0;
      resp_q   <= 1'b0;
    end
    else
    begin
      drive_q  <= drive_d;                                            // R09 R15
      DATA_OUT <= rd_word;                                            // R09 R14
      ext_q    <= state_d == ST_HOLD;                                 // R12
      resp_q   <= state_q == ST_ACT;                                  // R13
    end
  end

  assign DATA_OE   = drive_q;
  assign EXT_CYCLE = ext_q;
  assign RESPOND   = resp_q;

  chk_oe_read_only: assert property (@(posedge MCLK) disable iff (!RESET_N) DATA_OE |-> rd_q) // R09
    else $error("data driven on a write");
  chk_no_resp_miss: assert property (@(posedge MCLK) disable iff (!RESET_N) // R15
    (state_q == ST_IDLE && !take) |=> !RESPOND)
    else $error("response without selection");
  chk_ext_len: assert property (@(posedge MCLK) disable iff (!RESET_N) // R05
    (take && hit_rom) |=> EXT_CYCLE [*8])
    else $error("extended cycle too short");
  chk_ram_no_ext: assert property (@(posedge MCLK) disable iff (!RESET_N) // R03
    (take && !hit_rom) |=> !EXT_CYCLE ##1 RESPOND)
    else $error("read/write access not in one cycle");
  chk_ext_bound: assert property (@(posedge MCLK) disable iff (!RESET_N) // R12
    $rose(EXT_CYCLE) |-> ##[1:200] !EXT_CYCLE)
    else $error("extended cycle never ends");
  chk_mem_only: assert property (@(posedge MCLK) disable iff (!RESET_N) // R11
    (ADDR_STB && !MEM_SEL && state_q == ST_IDLE) |=> state_q == ST_IDLE)
    else $error("peripheral cycle accepted");
  chk_rom_no_wr: assert property (@(posedge MCLK) disable iff (!RESET_N) rom_q && state_q != ST_IDLE |-> !ram_we) // R06
    else $error("write reached store on read-only access");
  chk_resp_ends: assert property (@(posedge MCLK) disable iff (!RESET_N) // R07
    (state_q == ST_ACT && !ADDR_STB) |=> ##1 !RESPOND)
    else $error("response outlives the bus cycle");

  chk_ext_no_resp: assert property (@(posedge MCLK) disable iff (!RESET_N) // R05 R12
    EXT_CYCLE |-> !RESPOND)
    else $error("response during the extended hold");

  chk_ext_rom_only: assert property (@(posedge MCLK) disable iff (!RESET_N) // R05
    EXT_CYCLE |-> rom_q)
    else $error("extended cycle on a read/write access");

  chk_ext_then_resp: assert property (@(posedge MCLK) disable iff (!RESET_N) // R05 R13
    $fell(EXT_CYCLE) |=> RESPOND)
    else $error("no response after the extended hold");

  chk_oe_with_resp: assert property (@(posedge MCLK) disable iff (!RESET_N) // R09 R13
    DATA_OE |-> RESPOND)
    else $error("data driven without response");

  chk_peri_quiet: assert property (@(posedge MCLK) disable iff (!RESET_N) // R11 R15
    (ADDR_STB && !MEM_SEL && state_q == ST_IDLE) |=> (!DATA_OE && !EXT_CYCLE && !RESPOND))
    else $error("outputs moved on a peripheral cycle");

  chk_miss_quiet: assert property (@(posedge MCLK) disable iff (!RESET_N) // R04 R15
    (ADDR_STB && MEM_SEL && state_q == ST_IDLE && ADDR[ADDR_W-1 -: BANK_W] != BANK_SEL
      && !(ROM_EN && ADDR >= ROM_BASE)) |=> state_q == ST_IDLE)
    else $error("cycle taken outside the selected bank");

  chk_rom_take: assert property (@(posedge MCLK) disable iff (!RESET_N) // R06 R12
    (ADDR_STB && MEM_SEL && state_q == ST_IDLE && ROM_EN && ADDR >= ROM_BASE) |=> EXT_CYCLE)
    else $error("read-only address without extended cycle");

  chk_ram_take: assert property (@(posedge MCLK) disable iff (!RESET_N) // R03 R04
    (ADDR_STB && MEM_SEL && state_q == ST_IDLE && ADDR[ADDR_W-1 -: BANK_W] == BANK_SEL
      && !(ROM_EN && ADDR >= ROM_BASE)) |=> ##1 RESPOND)
    else $error("bank access not answered");

  chk_wr_no_oe: assert property (@(posedge MCLK) disable iff (!RESET_N) // R09
    (take && !RD_WR_N) |=> ##1 !DATA_OE)
    else $error("data lines driven on a write");

  chk_rd_oe: assert property (@(posedge MCLK) disable iff (!RESET_N) // R09
    (take && RD_WR_N && !hit_rom) |=> ##1 DATA_OE)
    else $error("read word not driven");

  chk_we_needs_stb: assert property (@(posedge MCLK) disable iff (!RESET_N) // R10
    ram_we |-> (DATA_STB && !rd_q))
    else $error("store written without data strobe");

  chk_hold_count: assert property (@(posedge MCLK) disable iff (!RESET_N) // R05
    (state_q == ST_HOLD && !ext_done) |=> cnt_q == $past(cnt_q) - CNT_W'(1))
    else $error("hold counter skipped");

  chk_cycle_holds: assert property (@(posedge MCLK) disable iff (!RESET_N) // R07
    (state_q == ST_ACT && ADDR_STB) |=> (state_q == ST_ACT && RESPOND))
    else $error("cycle ended while strobe held");

  chk_addr_latched: assert property (@(posedge MCLK) disable iff (!RESET_N) // R10
    take |=> addr_q == $past(ADDR))
    else $error("address not captured under strobe");
endmodule : bmm_memory

//--- tb/bmm_master.sv
// Purpose: bus master model for the memory module
// Assumes: one transfer at a time
// Notes:   released data lines show the inverse of the last word
`timescale 1ns/100ps
module bmm_master
  import bmm_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic [DATA_W-1:0] rd_data,
  input  wire logic              rd_oe,
  input  wire logic              respond,
  input  wire logic              ext,
  output logic                   addr_stb,
  output logic                   data_stb,
  output logic [ADDR_W-1:0]      addr,
  output logic                   mem_sel,
  output logic                   rd_wr_n,
  output logic [DATA_W-1:0]      wr_data,
  output logic                   done,
  output logic [18:0]            res
);
  initial
  begin
    {addr_stb, data_stb, mem_sel, rd_wr_n, done} = 5'b0_0000;
    addr = 16'h0000;
    wr_data = 16'h0000;
    res = 19'h0_0000;
  end
  localparam int WAIT_MAX = 400;
  task automatic xfer(input logic [15:0] a, input logic rd, input logic mem, input logic [15:0] wd);
    int n;
    logic oe;
    logic xt;
    n = 0;
    oe = 1'b0;
    xt = 1'b0;
    @(posedge mclk);
    addr_stb <= 1'b1;
    data_stb <= !rd;
    addr <= a;
    mem_sel <= mem;
    rd_wr_n <= rd;
    wr_data <= wd;
    do
    begin
      @(posedge mclk);
      n++;
      oe |= rd_oe;
      xt |= ext;
    end while (!respond && n < WAIT_MAX);
    res <= {respond, respond && xt && n > EXT_HOLD_CYC, oe, rd_data};
    done <= 1'b1;
    {addr_stb, data_stb} <= 2'b00;
    addr <= ~a;
    wr_data <= ~wd;
    @(posedge mclk);
    done <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask : xfer
endmodule : bmm_master

//--- tb/tb_bmm_memory.sv
// Purpose: self-checking bench for the bus memory module
// Assumes: master model drives all bus inputs
// Notes:   expected words queued per transfer
`timescale 1ns/100ps
module tb_bmm_memory;
  import bmm_pkg::*;
  logic MCLK = 1'b0, RESET_N = 1'b0;
  logic [3:0] bank = 4'h0;
  logic [31:0] rs = 32'h0000_0012;
  logic [15:0] a, mm [0:65535];
  logic [18:0] e, m, exp_q[$];
  int fail_count = 0, n_tests = 0;
  wire logic as, ds, ms, rw, oe, ext, rsp, done;
  wire logic [15:0] ad, wd, dout;
  wire logic [18:0] res;
  always #2 MCLK = ~MCLK;
  bmm_memory u_bmm_memory (.MCLK(MCLK), .RESET_N(RESET_N), .BANK_SEL(bank), .ADDR_STB(as), .DATA_STB(ds),
    .ADDR(ad), .MEM_SEL(ms), .RD_WR_N(rw), .DATA_IN(oe ? dout : wd), .DATA_OUT(dout), .DATA_OE(oe),
    .EXT_CYCLE(ext), .RESPOND(rsp));
  bmm_master u_bmm_master (.mclk(MCLK), .rd_data(dout), .rd_oe(oe), .respond(rsp), .ext(ext), .addr_stb(as),
    .data_stb(ds), .addr(ad), .mem_sel(ms), .rd_wr_n(rw), .wr_data(wd), .done(done), .res(res));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  task automatic op(input logic [15:0] ta, input logic rd, input logic mem);
    logic inr, rom;
    rs = xs(rs);
    rom = ta >= ROM_BASE;
    inr = mem && (ta[15:12] == bank || rom);
    if (inr && !rd && !rom) mm[ta] = rs[15:0];
    exp_q.push_back({inr, inr && rom, inr && rd, rom ? ROM_FILL : mm[ta]});
    u_bmm_master.xfer(ta, rd, mem, rs[15:0]);
  endtask : op
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict
  always @(negedge MCLK)
    if (done)
    begin
      e = exp_q.pop_front();
      m = {3'b111, {16{e[16]}}};
      n_tests++;
      if ((res & m) !== (e & m))
      begin
        fail_count++;
        $display("Error at %0t: got %h expected %h", $time, res, e);
      end
    end
  initial
  begin
    #(60000 * 4);
    fail_count++;
    give_verdict();
  end
  initial
  begin
    rs = xs(rs);
    bank = rs[3:0] % 4'hF;
    repeat (5) @(posedge MCLK);
    RESET_N <= 1'b1;
    repeat (2) @(posedge MCLK);
    for (int i = 0; i < 8; i++)
    begin
      a = {bank, rs[27:16]};
      op(a, 1'b0, 1'b1);
      op(a, 1'b1, 1'b1);
    end
    $display("test ram done");
    op(ROM_BASE, 1'b1, 1'b1);
    op(ROM_TOP, 1'b0, 1'b1);
    op(ROM_TOP, 1'b1, 1'b1);
    $display("test rom done");
    a = {bank + 4'h1, rs[11:0]};
    op(a, 1'b1, 1'b1);
    op(a, 1'b0, 1'b1);
    op({bank, rs[11:0]}, 1'b1, 1'b0);
    op({bank, rs[11:0]}, 1'b0, 1'b0);
    $display("test refuse done");
    repeat (4) @(posedge MCLK);
    give_verdict();
  end
endmodule : tb_bmm_memory
